// file: rpa_core.sv
// timekeeping core: supply switch decision, calendar, alarm, frequency output
// assumes host requests on bus_clk and pins asynchronous to ref_clk
// Contract
// - backup needs main below backup and trip
// - return when above backup or trip plus hysteresis
// - serial interface ignored while on backup
// - timekeeping and outputs keep running on backup
// - flag reports power-up after total loss
// - time frozen until clock section written
// - low power mode skips trip comparison
// - no backup draw before first main power
// - count calendar, leap years, 12/24 hour
// - short months roll over correctly
// - alarm needs enable; mode picks single/pulsed
// - frequency output disables alarm
// - single event pulls pin low, sets flag
// - pulsed mode pulls pin low 250 ms
// - only enabled alarm fields are compared
// - flag held until host or auto clear
// - one setting gates outputs on backup
// - fifteen frequencies chosen by select field
// - two user bytes kept on backup
// - digital trim shifts counter up to 60 ppm
// - analog trim switches load capacitors
// - select field picks interrupt or frequency
// - first clock write clears loss flag
module rpa_core
  import rpa_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
)
(
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic bus_clk,
  // pins: crystal time base and supply comparators
  input wire logic xtal_in,
  input wire rpa_supply_t supply_in,
  // host settings, levels held by the host
  input wire rpa_cfg_t cfg_in,
  input wire rpa_alarm_t alarm_in,
  // host requests, one bus_clk cycle each
  input wire logic time_wr,
  input wire rpa_time_t time_wr_data,
  input wire logic user_wr,
  input wire logic user_wr_sel,
  input wire logic [7:0] user_wr_data,
  input wire logic flag_clear,
  input wire logic status_read,
  // status and time
  output rpa_time_t time_now,
  output logic total_power_loss_flag,
  output logic alarm_status_flag,
  output logic backup_mode,
  output logic backup_draw_enable,
  output logic serial_if_enable,
  // shared interrupt / frequency pin, open drain
  output logic irq_freq_output_pin_o,
  output logic irq_freq_output_pin_oe,
  // trimming and user memory
  output logic [5:0] cap_select,
  output logic [1:0][7:0] user_mem
);

  // ---------------- link domain (bus_clk) ----------------
  logic bk_m; // backup state, first stage
  logic bk_s; // backup state, usable
  logic [3:0] req_tgl; // toggles: 0 time, 1 user, 2 clear, 3 read
  rpa_time_t time_hold; // time held for the other domain
  logic user_sel_hold;
  logic [7:0] user_data_hold;

  // backup state into the link domain
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bk_m <= 1'b0;
      bk_s <= 1'b0;
    end
    else
    begin
      bk_m <= backup_mode;
      bk_s <= bk_m;
    end
  end

  // requests become toggles with held data; data stays put until the next request
  always_ff @(posedge bus_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_tgl <= 4'h0;
      time_hold <= TIME_RESET;
      user_sel_hold <= 1'b0;
      user_data_hold <= 8'h00;
    end
    else if (!bk_s) // serial side dead on backup
    begin
      if (time_wr)
      begin
        req_tgl[0] <= ~req_tgl[0];
        time_hold <= time_wr_data;
      end
      if (user_wr)
      begin
        req_tgl[1] <= ~req_tgl[1];
        user_sel_hold <= user_wr_sel;
        user_data_hold <= user_wr_data;
      end
      if (flag_clear)
        req_tgl[2] <= ~req_tgl[2];
      if (status_read)
        req_tgl[3] <= ~req_tgl[3];
    end
  end

  // ---------------- reference domain (ref_clk) ----------------
  logic [3:0] tgl_m, tgl_s, tgl_d; // toggle synchroniser and history
  logic [3:0] req_evt; // one-cycle request events
  logic xt_m, xt_s, xt_d; // crystal synchroniser and history
  logic xtal_rise;
  rpa_supply_t sup_m, sup_s; // comparator synchroniser
  rpa_cfg_t cfg_m, cfg_s; // settings synchroniser
  rpa_alarm_t alm_m, alm_s; // alarm settings synchroniser
  rpa_pwr_t pwr_state, next_pwr;
  logic [15:0] presc; // crystal edges within the second
  logic [15:0] trim_amt;
  logic [15:0] presc_last;
  logic sec_tick; // one cycle per second
  logic tick_d; // cycle after the time advanced
  logic time_load;
  logic alarm_active, alarm_match, alarm_fire;
  logic [24:0] pulse_cnt; // pulsed low time remaining
  logic [14:0] freq_taps;
  logic out_gate; // pin outputs allowed in this supply state
  logic next_oe;

  // settings are quasi-static levels; wide sync is safe because they settle first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgl_m <= 4'h0;
      tgl_s <= 4'h0;
      tgl_d <= 4'h0;
      xt_m <= 1'b0;
      xt_s <= 1'b0;
      xt_d <= 1'b0;
      sup_m <= '0;
      sup_s <= '0;
      cfg_m <= '0;
      cfg_s <= '0;
      alm_m <= '0;
      alm_s <= '0;
    end
    else
    begin
      tgl_m <= req_tgl;
      tgl_s <= tgl_m;
      tgl_d <= tgl_s;
      xt_m <= xtal_in;
      xt_s <= xt_m;
      xt_d <= xt_s;
      sup_m <= supply_in;
      sup_s <= sup_m;
      cfg_m <= cfg_in;
      cfg_s <= cfg_m;
      alm_m <= alarm_in;
      alm_s <= alm_m;
    end
  end

  assign req_evt = tgl_s ^ tgl_d;
  assign xtal_rise = xt_s & ~xt_d;
  assign time_load = req_evt[0];

  // supply switch decision; the analog comparators carry the hysteresis
  always_comb
  begin
    next_pwr = pwr_state;
    case (pwr_state)
      PWR_SEALED:
        if (sup_s.main_present)
          next_pwr = PWR_MAIN;
      PWR_MAIN:
        if (cfg_s.low_power_switch_select)
        begin
          if (sup_s.main_below_backup)
            next_pwr = PWR_BACKUP;
        end
        else if (sup_s.main_below_backup && sup_s.main_below_trip)
          next_pwr = PWR_BACKUP;
      PWR_BACKUP:
        if (sup_s.main_above_backup || sup_s.main_above_trip)
          next_pwr = PWR_MAIN;
      default:
        next_pwr = PWR_SEALED;
    endcase
  end

  // supply state and its outputs move together
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_state <= PWR_SEALED;
      backup_mode <= 1'b0;
      backup_draw_enable <= 1'b0;
      serial_if_enable <= 1'b1;
    end
    else
    begin
      pwr_state <= next_pwr;
      backup_mode <= (next_pwr == PWR_BACKUP);
      backup_draw_enable <= (next_pwr != PWR_SEALED);
      serial_if_enable <= (next_pwr != PWR_BACKUP);
    end
  end

  // trim of 30.5 ppm per crystal edge; magnitude clamps at two edges
  assign trim_amt = (16'({14'h0, cfg_s.digital_trim[1:0]}) > TRIM_MAX) ? TRIM_MAX
                    : 16'({14'h0, cfg_s.digital_trim[1:0]});
  assign presc_last = cfg_s.digital_trim[2] ? (XTAL_LAST - trim_amt)
                      : (XTAL_LAST + trim_amt);

  // one-second divider, runs on every supply
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc <= PRESC_RESET;
      sec_tick <= 1'b0;
      tick_d <= 1'b0;
    end
    else
    begin
      sec_tick <= 1'b0;
      tick_d <= sec_tick;
      if (time_load) // a fresh time starts a full second
        presc <= PRESC_RESET;
      else if (xtal_rise)
      begin
        if (presc >= presc_last)
        begin
          presc <= PRESC_RESET;
          sec_tick <= 1'b1;
        end
        else
          presc <= presc + 16'h0001;
      end
    end
  end

  // days in the month; years 00..99 stand for 2000..2099
  function automatic logic [4:0] month_days(input logic [3:0] month, input logic [6:0] year);
    logic [4:0] days;
    days = 5'h1F;
    case (month)
      4'h2: days = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB: days = 5'h1E;
      default: days = 5'h1F;
    endcase
    return days;
  endfunction : month_days

  // one second later
  function automatic rpa_time_t time_step(input rpa_time_t t);
    rpa_time_t n;
    logic day_roll;
    n = t;
    day_roll = 1'b0;
    if (t.sec >= SEC_MAX)
    begin
      n.sec = 6'h00;
      if (t.min >= MIN_MAX)
      begin
        n.min = 6'h00;
        if (t.mil) // 24-hour format
        begin
          if (t.hour >= HOUR24_MAX)
          begin
            n.hour = 5'h00;
            day_roll = 1'b1;
          end
          else
            n.hour = t.hour + 5'h01;
        end
        else if (t.hour == HOUR12_PRE) // 11 -> 12 flips am/pm
        begin
          n.hour = HOUR12_TOP;
          n.pm = ~t.pm;
          day_roll = t.pm;
        end
        else if (t.hour >= HOUR12_TOP)
          n.hour = 5'h01;
        else
          n.hour = t.hour + 5'h01;
      end
      else
        n.min = t.min + 6'h01;
    end
    else
      n.sec = t.sec + 6'h01;
    if (day_roll)
    begin
      n.wday = (t.wday >= WDAY_MAX) ? 3'h0 : t.wday + 3'h1;
      if (t.date >= month_days(t.month, t.year))
      begin
        n.date = 5'h01;
        if (t.month >= MONTH_MAX)
        begin
          n.month = 4'h1;
          n.year = (t.year >= YEAR_MAX) ? 7'h00 : t.year + 7'h01;
        end
        else
          n.month = t.month + 4'h1;
      end
      else
        n.date = t.date + 5'h01;
    end
    return n;
  endfunction : time_step

  // calendar counters; a host write wins over a tick in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      time_now <= TIME_RESET;
    else if (time_load)
      time_now <= time_hold;
    else if (sec_tick && !total_power_loss_flag)
      time_now <= time_step(time_now);
  end

  // total loss flag: raised by the power-up reset, dropped by a clock write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      total_power_loss_flag <= LOSS_FLAG_RESET;
    else if (time_load)
      total_power_loss_flag <= 1'b0;
  end

  // user bytes; only the write path stops on backup, contents stay
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      user_mem <= '0;
    else if (req_evt[1])
      user_mem[user_sel_hold] <= user_data_hold;
  end

  // alarm may fire: enabled, pin not in frequency mode, not gated by backup
  assign out_gate = !(backup_mode && cfg_s.backup_output_disable);
  assign alarm_active = cfg_s.alarm_enable_bit
                        && (cfg_s.freq_select_field == FREQ_OFF)
                        && out_gate;

  // compare only enabled fields; with none enabled nothing fires
  assign alarm_match = (alm_s.en_sec || alm_s.en_min || alm_s.en_hour
                        || alm_s.en_date || alm_s.en_month || alm_s.en_wday)
    && (!alm_s.en_sec || (time_now.sec == alm_s.sec))
    && (!alm_s.en_min || (time_now.min == alm_s.min))
    && (!alm_s.en_hour || ((time_now.hour == alm_s.hour)
                           && (time_now.mil || (time_now.pm == alm_s.pm))))
    && (!alm_s.en_date || (time_now.date == alm_s.date))
    && (!alm_s.en_month || (time_now.month == alm_s.month))
    && (!alm_s.en_wday || (time_now.wday == alm_s.wday));

  // checked once, the cycle after the time advanced
  assign alarm_fire = tick_d && alarm_active && alarm_match;

  // alarm status: a new match beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      alarm_status_flag <= 1'b0;
    else if (alarm_fire)
      alarm_status_flag <= 1'b1;
    else if (req_evt[2] || (req_evt[3] && cfg_s.status_auto_clear))
      alarm_status_flag <= 1'b0;
  end

  // pulsed mode low time; a new match restarts it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pulse_cnt <= 25'h0000000;
    else if (alarm_fire && cfg_s.alarm_pulse_select)
      pulse_cnt <= 25'(PULSE_CYCLES - 1);
    else if (pulse_cnt != 25'h0000000)
      pulse_cnt <= pulse_cnt - 25'h0000001;
  end

  // tap 0 is the crystal itself, higher taps halve each step
  assign freq_taps = {presc[13:0], xt_s};

  // shared pin: select field zero means interrupt, otherwise a clock
  always_comb
  begin
    next_oe = 1'b0;
    if (cfg_s.freq_select_field != FREQ_OFF)
      next_oe = out_gate && !freq_taps[4'(cfg_s.freq_select_field - 4'h1)];
    else if (cfg_s.alarm_pulse_select)
      next_oe = out_gate && (pulse_cnt != 25'h0000000);
    else
      next_oe = out_gate && alarm_status_flag;
  end

  // open drain: output is always low, enable pulls the wire
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_freq_output_pin_o <= 1'b0;
      irq_freq_output_pin_oe <= 1'b0;
    end
    else
    begin
      irq_freq_output_pin_o <= 1'b0;
      irq_freq_output_pin_oe <= next_oe;
    end
  end

  // load capacitor switches follow the analog trim setting
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_select <= 6'h00;
    else
      cap_select <= cfg_s.analog_trim_setting;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_enter_needs_both: assert property (
    (pwr_state == PWR_MAIN) && !cfg_s.low_power_switch_select
    && sup_s.main_below_backup && !sup_s.main_below_trip |=> (pwr_state == PWR_MAIN))
    else $error("backup entered without trip condition");

  a_lp_enter_backup: assert property (
    (pwr_state == PWR_MAIN) && cfg_s.low_power_switch_select && sup_s.main_below_backup
    |=> backup_mode && (pwr_state == PWR_BACKUP))
    else $error("low power mode did not switch to backup");

  a_return_to_main: assert property (
    (pwr_state == PWR_BACKUP) && (sup_s.main_above_backup || sup_s.main_above_trip)
    |=> !backup_mode && serial_if_enable)
    else $error("no return to main supply");

  a_sealed_no_draw: assert property (
    (pwr_state == PWR_SEALED) && !sup_s.main_present |=> !backup_draw_enable && !backup_mode)
    else $error("backup drawn before first main power");

  a_serial_off_backup: assert property (
    backup_mode |-> !serial_if_enable)
    else $error("serial interface active on backup");

  a_frozen_time: assert property (
    total_power_loss_flag && !time_load |=> $stable(time_now))
    else $error("time advanced after total power loss");

  a_loss_flag_clear: assert property (
    time_load |=> !total_power_loss_flag && (time_now == $past(time_hold)))
    else $error("clock write did not clear loss flag");

  a_freq_blocks_alarm: assert property (
    (cfg_s.freq_select_field != FREQ_OFF) |-> !alarm_fire)
    else $error("alarm fired in frequency mode");

  a_alarm_sets_flag: assert property (
    alarm_fire |=> alarm_status_flag)
    else $error("alarm match did not set status flag");

  a_pulse_low_time: assert property (
    alarm_fire && cfg_s.alarm_pulse_select && out_gate
    ##1 (cfg_s.freq_select_field == FREQ_OFF) |=> irq_freq_output_pin_oe [*8])
    else $error("pulsed alarm low time too short");

  a_single_pin_low: assert property (
    alarm_status_flag && !cfg_s.alarm_pulse_select && out_gate
    && (cfg_s.freq_select_field == FREQ_OFF) |=> irq_freq_output_pin_oe)
    else $error("single event alarm did not pull pin low");

endmodule : rpa_core

// file: rpa_pkg.sv
// shared types and constants for the calendar clock core with supply switching
// assumes a 100 MHz reference clock and a 32.768 kHz crystal square wave on a pin
package rpa_pkg;

  // clock rate and timing figures
  localparam int unsigned REF_CLK_HZ = 100_000_000; // reference clock rate
  localparam int unsigned PULSE_MS = 250; // pulsed alarm low time, ms
  // pulse low time in reference cycles, derived from the figure above
  localparam int unsigned PULSE_CYC = REF_CLK_HZ / 1000 * PULSE_MS;

  // comparator thresholds, kept for reference; the comparators are analog
  localparam int unsigned BACKUP_COMPARE_HYSTERESIS_MV = 50;
  localparam int unsigned SWITCH_TRIP_LEVEL_MV = 2200;
  localparam int unsigned TRIP_COMPARE_HYSTERESIS_MV = 30;

  // crystal divider: 32768 crystal edges make one second
  localparam logic [15:0] XTAL_LAST = 16'h7FFF; // last prescaler count
  localparam logic [15:0] TRIM_MAX = 16'h0002; // largest trim, crystal edges/s
  localparam logic [15:0] PRESC_RESET = 16'h0000;

  // calendar limits
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR24_MAX = 5'h17;
  localparam logic [4:0] HOUR12_PRE = 5'h0B;
  localparam logic [4:0] HOUR12_TOP = 5'h0C;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [6:0] YEAR_MAX = 7'h63;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [3:0] FREQ_OFF = 4'h0; // frequency select value for interrupt mode

  // present time, binary fields
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] date;
    logic [2:0] wday;
    logic mil; // 1: 24-hour format
    logic pm; // pm indicator in 12-hour format
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rpa_time_t;

  // reset time: 12-hour format, all zero
  localparam rpa_time_t TIME_RESET = '0;
  localparam logic LOSS_FLAG_RESET = 1'b1; // flag raised by power-up after total loss

  // alarm settings with per-field compare enables
  typedef struct packed {
    logic en_sec, en_min, en_hour, en_date, en_month, en_wday;
    logic [5:0] sec;
    logic [5:0] min;
    logic pm;
    logic [4:0] hour;
    logic [4:0] date;
    logic [3:0] month;
    logic [2:0] wday;
  } rpa_alarm_t;

  // control settings from the host
  typedef struct packed {
    logic alarm_enable_bit;
    logic alarm_pulse_select; // 1: pulsed recurring, 0: single event
    logic status_auto_clear;
    logic low_power_switch_select;
    logic backup_output_disable;
    logic [3:0] freq_select_field;
    logic [5:0] analog_trim_setting;
    logic [2:0] digital_trim; // [2]=1 speeds up, [1:0] edges per second
  } rpa_cfg_t;

  // supply comparator outputs
  typedef struct packed {
    logic main_below_backup; // main < backup - hysteresis
    logic main_below_trip; // main < trip level
    logic main_above_backup; // main > backup + hysteresis
    logic main_above_trip; // main > trip level + hysteresis
    logic main_present; // main supply has come up
  } rpa_supply_t;

  // supply switch states
  typedef enum logic [1:0] {PWR_SEALED, PWR_MAIN, PWR_BACKUP} rpa_pwr_t;

endpackage : rpa_pkg

// file: rpa_host_model.sv
// host side model: issues link requests on bus_clk, one pulse per request
// assumes the bench calls its tasks and that bus_clk runs continuously
module rpa_host_model
  import rpa_pkg::*;
(
  // link clock
  input wire logic bus_clk,
  // requests toward the core
  output logic time_wr,
  output rpa_time_t time_wr_data,
  output logic user_wr,
  output logic user_wr_sel,
  output logic [7:0] user_wr_data,
  output logic flag_clear,
  output logic status_read
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: no request, data lines scrambled since nothing qualifies them
  initial
  begin
    time_wr = 1'b0;
    time_wr_data = '1;
    user_wr = 1'b0;
    user_wr_sel = 1'b0;
    user_wr_data = 8'hA5;
    flag_clear = 1'b0; // raised only by send_flag
    status_read = 1'b0;
  end

  // whole time struct in one pulse; spare edge keeps same-kind spacing
  task send_time(input rpa_time_t d);
    @(posedge bus_clk);
    time_wr <= 1'b1;
    time_wr_data <= d;
    @(posedge bus_clk);
    time_wr <= 1'b0;
    time_wr_data <= ~d; // released data must not look valid
    @(posedge bus_clk);
  endtask : send_time

  // one user byte, chosen by the select line
  task send_user(input logic sel, input logic [7:0] d);
    @(posedge bus_clk);
    user_wr <= 1'b1;
    user_wr_sel <= sel;
    user_wr_data <= d;
    @(posedge bus_clk);
    user_wr <= 1'b0;
    user_wr_data <= ~d;
    @(posedge bus_clk);
  endtask : send_user

  // alarm flag request: a status read, or the host clear when rd is low
  task send_flag(input logic rd);
    @(posedge bus_clk);
    status_read <= rd;
    flag_clear <= !rd;
    @(posedge bus_clk);
    status_read <= 1'b0;
    flag_clear <= 1'b0;
    @(posedge bus_clk);
  endtask : send_flag
endmodule : rpa_host_model

// file: rpa_core_test.sv
// self-checking bench for the calendar core: supply switch, link, outputs
// assumes the first seconds tick arrives only near the end, where the alarm test waits for it
module rpa_core_test;
  import rpa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // clocks, reset and pins
  logic ref_clk = 1'b0;
  logic bus_clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal = 1'b0;
  rpa_supply_t supply = '0;
  rpa_cfg_t cfg = '0;
  rpa_alarm_t alarm = '0;
  // link requests from the host model
  logic time_wr, user_wr, user_sel, flag_clear, status_read;
  rpa_time_t wr_data, t_exp;
  logic [7:0] user_data;
  // outputs
  rpa_time_t time_now;
  logic loss_flag, alarm_flag, backup_mode, draw_en, serial_en, irq_o, irq_oe;
  logic [5:0] cap_select;
  logic [1:0][7:0] user_mem;
  logic [7:0] u0, u1;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  // mode table: {low power, below backup, below trip, above backup, above trip, mode}
  logic [5:0] tbl [8] = '{6'h10, 6'h08, 6'h19, 6'h02, 6'h19, 6'h04, 6'h31, 6'h24};

  initial forever #5 ref_clk = ~ref_clk;
  // link clock, unrelated phase
  initial
  begin
    #7;
    forever #24 bus_clk = ~bus_clk;
  end
  // fast crystal stand-in: one edge per cycle makes a second last 65536 cycles
  always @(posedge ref_clk)
    xtal <= ~xtal;

  rpa_host_model host (.bus_clk(bus_clk), .time_wr(time_wr), .time_wr_data(wr_data),
    .user_wr(user_wr), .user_wr_sel(user_sel), .user_wr_data(user_data),
    .flag_clear(flag_clear), .status_read(status_read));

  rpa_core #(.PULSE_CYCLES(40)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_clk(bus_clk),
    .xtal_in(xtal), .supply_in(supply), .cfg_in(cfg), .alarm_in(alarm), .time_wr(time_wr),
    .time_wr_data(wr_data), .user_wr(user_wr), .user_wr_sel(user_sel),
    .user_wr_data(user_data), .flag_clear(flag_clear), .status_read(status_read),
    .time_now(time_now), .total_power_loss_flag(loss_flag), .alarm_status_flag(alarm_flag),
    .backup_mode(backup_mode), .backup_draw_enable(draw_en), .serial_if_enable(serial_en),
    .irq_freq_output_pin_o(irq_o), .irq_freq_output_pin_oe(irq_oe), .cap_select(cap_select), .user_mem(user_mem));

  task close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // compare with case equality so an unknown never matches a known value
  task check(input logic [37:0] got, input logic [37:0] exp);
    total_checks++;
    if (got !== exp)
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    if (got !== exp)
      fail_count++;
  endtask : check

  // settle just past an edge so registered outputs have landed
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : tick

  // bounded wait for the power mode; sync latency varies by a cycle or two
  task wait_mode(input logic m);
    int i;
    i = 0;
    tick(8);
    while (backup_mode !== m && i < 20)
    begin
      tick(1);
      i++;
    end
    check({37'h0, backup_mode}, {37'h0, m});
    if (backup_mode !== m)
      close_out();
  endtask : wait_mode

  // pin rising edges over 96 reference cycles, sampled once settled
  task count_rises(output int r);
    logic prev;
    r = 0;
    prev = irq_oe;
    repeat (96)
    begin
      tick(1);
      if (irq_oe === 1'b1 && prev === 1'b0)
        r++;
      prev = irq_oe;
    end
  endtask : count_rises

  // legal random time, 24-hour format
  function automatic rpa_time_t rand_time();
    rpa_time_t t;
    t = '0;
    t.year = 7'($urandom_range(99));
    t.month = 4'($urandom_range(12, 1));
    t.date = 5'($urandom_range(28, 1));
    t.wday = 3'($urandom_range(6));
    t.mil = 1'b1;
    t.hour = 5'($urandom_range(23));
    t.min = 6'($urandom_range(59));
    t.sec = 6'($urandom_range(59));
    return t;
  endfunction : rand_time

  // seconds field one second later
  function automatic logic [5:0] next_sec(input logic [5:0] s);
    return (s >= SEC_MAX) ? 6'h00 : s + 6'h01;
  endfunction : next_sec

  // frequency select k gives crystal divided by 2 to the k-1
  task check_freq(input logic [3:0] k, input int exp);
    @(posedge ref_clk);
    cfg.freq_select_field <= k;
    tick(10);
    count_rises(n);
    check(38'(n > exp + 1 || n + 1 < exp), 38'h0);
  endtask : check_freq

  initial
  begin
    void'($urandom(93176));
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    check({loss_flag, serial_en, draw_en, backup_mode, irq_oe}, 38'h18);
    check(time_now, '0);
    // both supplies low before first main power: no switch, no draw
    @(posedge ref_clk);
    supply <= 5'h18;
    tick(10);
    check({draw_en, backup_mode}, 38'h0);
    @(posedge ref_clk);
    supply <= 5'h01;
    tick(10);
    check(draw_en, 38'h1);
    @(posedge ref_clk);
    cfg.analog_trim_setting <= 6'($urandom);
    tick(10);
    check(cap_select, cfg.analog_trim_setting);
    u0 = 8'($urandom);
    u1 = 8'($urandom);
    host.send_user(1'b0, u0);
    host.send_user(1'b1, u1);
    t_exp = rand_time();
    host.send_time(t_exp);
    tick(8);
    check(user_mem, {u1, u0});
    check(time_now, t_exp);
    check(loss_flag, 38'h0);
    // switch decision table, each line from the mode left by the last
    foreach (tbl[i])
    begin
      @(posedge ref_clk);
      cfg.low_power_switch_select <= tbl[i][5];
      supply <= {tbl[i][4:1], 1'b1};
      wait_mode(tbl[i][0]);
      check(serial_en, !tbl[i][0]);
    end
    check_freq(4'h1, 48);
    check_freq(4'h2, 24);
    check_freq(4'h3, 12);
    // on backup: link refused, output still runs unless gated
    @(posedge ref_clk);
    supply <= 5'h19;
    wait_mode(1'b1);
    check_freq(4'h2, 24);
    @(posedge ref_clk);
    cfg.backup_output_disable <= 1'b1;
    check_freq(4'h2, 0);
    host.send_user(1'b0, ~u0);
    host.send_time(rand_time());
    tick(8);
    check(user_mem, {u1, u0});
    check(time_now, t_exp);
    @(posedge ref_clk);
    supply <= 5'h07;
    wait_mode(1'b0);
    check_freq(4'h0, 0);
    check({irq_o, alarm_flag}, 38'h0);
    // seconds alarm one second past the written time; waits for the first tick
    @(posedge ref_clk);
    cfg.alarm_enable_bit <= 1'b1;
    alarm.en_sec <= 1'b1;
    alarm.sec <= next_sec(t_exp.sec);
    n = 0;
    while (alarm_flag !== 1'b1 && n < 70000)
    begin
      tick(1);
      n++;
    end
    check(alarm_flag, 38'h1);
    if (alarm_flag !== 1'b1)
      close_out();
    tick(1);
    check(irq_oe, 38'h1);
    check(time_now.sec, next_sec(t_exp.sec));
    // a read without auto clear keeps the flag; the host clear drops it
    host.send_flag(1'b1);
    tick(8);
    check(alarm_flag, 38'h1);
    host.send_flag(1'b0);
    tick(8);
    check({alarm_flag, irq_oe}, 38'h0);
    close_out();
  end
endmodule : rpa_core_test
